// ==== dbgtc_regs.svh ====
`ifndef DBGTC_REGS_SVH
`define DBGTC_REGS_SVH

// ********************
// Register offsets.
// ********************
`define DBGTC_OFS_CONTROL 8'h20
`define DBGTC_OFS_STATUS 8'h21

// ********************
// Control register field positions.
// ********************
`define DBGTC_CTL_ENABLE_BIT 7
`define DBGTC_CTL_ARM_BIT 6
`define DBGTC_CTL_TSEL_BIT 5
`define DBGTC_CTL_BEGIN_BIT 4
`define DBGTC_CTL_BRK_BIT 3
`define DBGTC_CTL_CAP_MSB 1
`define DBGTC_CTL_CAP_LSB 0

// ********************
// Status register field positions.
// ********************
`define DBGTC_STS_FLAG_A_BIT 7
`define DBGTC_STS_FLAG_B_BIT 6
`define DBGTC_STS_FLAG_C_BIT 5
`define DBGTC_STS_TRG_MSB 3
`define DBGTC_STS_TRG_LSB 0

// ********************
// Reset values.
// ********************
`define DBGTC_RST_CONTROL 8'h00
`define DBGTC_RST_STATUS 8'h00
`define DBGTC_RST_RDATA 8'h00

`endif

// ==== dbgtc_pkg.sv ====
package dbgtc_pkg;

  // ********************
  // Capture modes.
  // ********************
  typedef enum logic [1:0] {
    DBGTC_CAP_NORMAL = 2'b00,
    DBGTC_CAP_DUP_SUPPRESS = 2'b01,
    DBGTC_CAP_DETAIL = 2'b10,
    DBGTC_CAP_PROFILE = 2'b11
  } dbgtc_cap_t;

  // ********************
  // Trigger modes; codes above outside range are reserved.
  // ********************
  typedef enum logic [3:0] {
    DBGTC_TRG_A_ONLY = 4'h0,
    DBGTC_TRG_A_OR_B = 4'h1,
    DBGTC_TRG_A_THEN_B = 4'h2,
    DBGTC_TRG_EVENT_B = 4'h3,
    DBGTC_TRG_A_THEN_EVENT_B = 4'h4,
    DBGTC_TRG_A_AND_B = 4'h5,
    DBGTC_TRG_A_NOT_B = 4'h6,
    DBGTC_TRG_INSIDE = 4'h7,
    DBGTC_TRG_OUTSIDE = 4'h8
  } dbgtc_trg_t;

  // ********************
  // Trigger sequencer states.
  // ********************
  typedef enum logic [1:0] {
    DBGTC_SEQ_WAIT_FIRST = 2'b00,
    DBGTC_SEQ_WAIT_SECOND = 2'b01,
    DBGTC_SEQ_FIRED = 2'b10
  } dbgtc_seq_t;

endpackage

// ==== dbgtc_trig.sv ====
`timescale 1ns/10ps

// ********************
// Trigger sequencer: turns comparator matches into trigger events.
// ********************
module dbgtc_trig (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic armed_in,
  input wire logic restart_in,
  input wire logic [3:0] trigger_mode_field_in,
  input wire logic match_a_in,
  input wire logic match_b_in,
  input wire logic in_range_in,
  output logic trig_a_out,
  output logic trig_b_out,
  output logic trigger_out,
  output logic event_store_out
);
  import dbgtc_pkg::*;

  dbgtc_trg_t mode;
  dbgtc_seq_t state_ff;
  dbgtc_seq_t nxt_state;
  wire logic seq_mode;
  wire logic first_seen;
  wire logic raw_trigger;

  // Reserved codes fall back to the single comparator mode.
  assign mode = (trigger_mode_field_in > 4'h8) ? DBGTC_TRG_A_ONLY :
                dbgtc_trg_t'(trigger_mode_field_in); // R18

  assign seq_mode = (mode == DBGTC_TRG_A_THEN_B) || (mode == DBGTC_TRG_A_THEN_EVENT_B);
  assign first_seen = (state_ff == DBGTC_SEQ_WAIT_SECOND);

  always_comb begin
    trig_a_out = 1'b0;
    trig_b_out = 1'b0;
    event_store_out = 1'b0;
    case (mode) // R16 R17
      DBGTC_TRG_A_ONLY: begin
        trig_a_out = match_a_in;
      end
      DBGTC_TRG_A_OR_B: begin
        trig_a_out = match_a_in;
        trig_b_out = match_b_in;
      end
      DBGTC_TRG_A_THEN_B: begin
        trig_a_out = match_a_in;
        trig_b_out = match_b_in && first_seen;
      end
      DBGTC_TRG_EVENT_B: begin
        trig_b_out = match_b_in;
        event_store_out = match_b_in;
      end
      DBGTC_TRG_A_THEN_EVENT_B: begin
        trig_a_out = match_a_in;
        trig_b_out = match_b_in && first_seen;
        event_store_out = match_b_in && first_seen;
      end
      DBGTC_TRG_A_AND_B: begin
        trig_a_out = match_a_in && match_b_in;
        trig_b_out = match_a_in && match_b_in;
      end
      DBGTC_TRG_A_NOT_B: begin
        trig_a_out = match_a_in && !match_b_in;
        trig_b_out = match_a_in && !match_b_in;
      end
      DBGTC_TRG_INSIDE: begin
        trig_a_out = in_range_in;
        trig_b_out = in_range_in;
      end
      DBGTC_TRG_OUTSIDE: begin
        trig_a_out = !in_range_in;
        trig_b_out = !in_range_in;
      end
      default: begin
        trig_a_out = match_a_in;
      end
    endcase
  end

  assign raw_trigger = seq_mode ? trig_b_out :
                       (mode == DBGTC_TRG_A_OR_B) ? (trig_a_out || trig_b_out) :
                       (mode == DBGTC_TRG_EVENT_B) ? trig_b_out : trig_a_out;
  assign trigger_out = armed_in && (state_ff != DBGTC_SEQ_FIRED) && raw_trigger;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DBGTC_SEQ_WAIT_FIRST: begin
        if (trigger_out) begin
          nxt_state = DBGTC_SEQ_FIRED;
        end else if (armed_in && seq_mode && match_a_in) begin
          nxt_state = DBGTC_SEQ_WAIT_SECOND;
        end
      end
      DBGTC_SEQ_WAIT_SECOND: begin
        if (trigger_out) begin
          nxt_state = DBGTC_SEQ_FIRED;
        end
      end
      DBGTC_SEQ_FIRED: begin
        nxt_state = DBGTC_SEQ_FIRED;
      end
      default: begin
        nxt_state = DBGTC_SEQ_WAIT_FIRST;
      end
    endcase
    if (restart_in || !armed_in) begin
      nxt_state = DBGTC_SEQ_WAIT_FIRST;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= DBGTC_SEQ_WAIT_FIRST;
    end else begin
      state_ff <= nxt_state;
    end
  end

endmodule

// ==== dbgtc_ctrl.sv ====
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`include "dbgtc_regs.svh"

// Notes on behaviour
// R1 - Control register writes are ignored while legacy breakpoint mode is enabled.
// R2 - Control bit 7 enables debug operation; cannot be set in secure mode.
// R3 - Control bit 6 arms comparing and trace storing; clearing it stops both.
// R4 - Arm sets only when the same write sets enable; 01 acts as 00.
// R5 - Control bit 5 picks address-match or tagged triggering for comparators A, B.
// R6 - With break enabled, bit 5 also picks the breakpoint type.
// R7 - Control bit 4: 0 trigger ends storing, 1 trigger begins storing.
// R8 - Control bit 3 requests a CPU break when a tracing session completes.
// R9 - Capture field: 00 normal, 01 duplicate suppress, 10 detail, 11 profile.
// R10 - Duplicate suppress mode skips repeated entries into the trace memory.
// R11 - Detail mode stores every bus cycle except program fetch and free cycles.
// R12 - Profile mode returns the most recently executed instruction address.
// R13 - Status bit 7 flags trigger A after arming; cleared by arm write or status write.
// R14 - Status bit 6 flags trigger B after arming; cleared by arm write or status write.
// R15 - Status bit 5 flags comparator C after arming; cleared likewise.
// R16 - Trigger field 0000 to 0100: A, A or B, A then B, B, A then B.
// R17 - Field 0101 A and B, 0110 A not B, 0111 inside, 1000 outside range.
// R18 - Field values 1001 to 1111 behave as the A only mode.
// R19 - While armed only the enable and arm bits accept writes.
// R20 - Control bit 2 and status bit 4 read zero and ignore writes.
module dbgtc_ctrl #(
  parameter int ADDR_W = 8,
  parameter int BUS_ADDR_W = 16
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic secure_mode_in,
  input wire logic legacy_breakpoint_enable_in,
  input wire logic match_a_in,
  input wire logic match_b_in,
  input wire logic match_c_in,
  input wire logic in_range_in,
  input wire logic bus_valid_in,
  input wire logic bus_prog_fetch_in,
  input wire logic bus_free_in,
  input wire logic bus_cof_in,
  input wire logic [BUS_ADDR_W-1:0] bus_addr_in,
  input wire logic instr_exec_in,
  input wire logic [BUS_ADDR_W-1:0] instr_addr_in,
  input wire logic session_done_in,
  output logic debug_operation_enable_out,
  output logic armed_out,
  output logic trigger_type_select_out,
  output logic begin_trigger_out,
  output dbgtc_pkg::dbgtc_cap_t capture_mode_field_out,
  output logic [3:0] trigger_mode_field_out,
  output logic compare_enable_out,
  output logic trigger_out,
  output logic store_strobe_out,
  output logic [BUS_ADDR_W-1:0] store_addr_out,
  output logic [BUS_ADDR_W-1:0] profile_addr_out,
  output logic cpu_break_request_out,
  output logic break_tagged_out
);
  import dbgtc_pkg::*;

  // ********************
  // Parameter checks.
  // ********************
  if (ADDR_W < 6) begin : g_addr_check
    $error("ADDR_W too small to hold the register offsets.");
  end
  if (BUS_ADDR_W < 1) begin : g_bus_check
    $error("BUS_ADDR_W must be at least one.");
  end

  // ********************
  // Register state.
  // ********************
  logic debug_enable_ff;
  logic arm_ff;
  logic tsel_ff;
  logic begin_ff;
  logic brk_ff;
  dbgtc_cap_t cap_ff;
  logic [3:0] trg_ff;
  logic flag_a_ff;
  logic flag_b_ff;
  logic flag_c_ff;
  logic [7:0] rdata_ff;
  logic triggered_ff;
  logic store_ff;
  logic [BUS_ADDR_W-1:0] store_addr_ff;
  logic [BUS_ADDR_W-1:0] last_store_ff;
  logic last_valid_ff;
  logic [BUS_ADDR_W-1:0] profile_ff;
  logic break_ff;
  logic trigger_ff;

  logic nxt_debug_enable;
  logic nxt_arm;
  logic nxt_tsel;
  logic nxt_begin;
  logic nxt_brk;
  dbgtc_cap_t nxt_cap;
  logic [3:0] nxt_trg;
  logic nxt_flag_a;
  logic nxt_flag_b;
  logic nxt_flag_c;
  logic nxt_triggered;

  // ********************
  // Address decode and write qualification.
  // ********************
  wire logic sel_control;
  wire logic sel_status;
  wire logic wr_control;
  wire logic wr_status;
  wire logic wr_enable_bit;
  wire logic wr_arm_bit;
  wire logic arm_restart;
  wire logic [7:0] control_view;
  wire logic [7:0] status_view;
  wire logic [7:0] read_mux;

  assign sel_control = (reg_addr_in == ADDR_W'(`DBGTC_OFS_CONTROL));
  assign sel_status = (reg_addr_in == ADDR_W'(`DBGTC_OFS_STATUS));
  assign wr_control = reg_wr_in && sel_control && !legacy_breakpoint_enable_in; // R1
  assign wr_status = reg_wr_in && sel_status && !arm_ff; // R19
  assign wr_enable_bit = reg_wdata_in[`DBGTC_CTL_ENABLE_BIT] && !secure_mode_in; // R2
  assign wr_arm_bit = reg_wdata_in[`DBGTC_CTL_ARM_BIT] && wr_enable_bit; // R4
  assign arm_restart = wr_control && wr_arm_bit;

  // ********************
  // Trigger sequencer.
  // ********************
  wire logic trig_a;
  wire logic trig_b;
  wire logic trig_event;
  wire logic event_store;

  dbgtc_trig u_trig (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .armed_in(arm_ff),
    .restart_in(arm_restart),
    .trigger_mode_field_in(trg_ff),
    .match_a_in(match_a_in),
    .match_b_in(match_b_in),
    .in_range_in(in_range_in),
    .trig_a_out(trig_a),
    .trig_b_out(trig_b),
    .trigger_out(trig_event),
    .event_store_out(event_store)
  );

  // ********************
  // Control and status next values.
  // ********************
  always_comb begin
    nxt_debug_enable = debug_enable_ff;
    nxt_arm = arm_ff;
    nxt_tsel = tsel_ff;
    nxt_begin = begin_ff;
    nxt_brk = brk_ff;
    nxt_cap = cap_ff;
    nxt_trg = trg_ff;
    if (wr_control) begin
      nxt_debug_enable = wr_enable_bit; // R2
      nxt_arm = wr_arm_bit; // R3 R4
      if (!arm_ff) begin // R19
        nxt_tsel = reg_wdata_in[`DBGTC_CTL_TSEL_BIT]; // R5
        nxt_begin = reg_wdata_in[`DBGTC_CTL_BEGIN_BIT]; // R7
        nxt_brk = reg_wdata_in[`DBGTC_CTL_BRK_BIT]; // R8
        nxt_cap = dbgtc_cap_t'(reg_wdata_in[`DBGTC_CTL_CAP_MSB:`DBGTC_CTL_CAP_LSB]); // R9
      end
    end else if (session_done_in && arm_ff) begin
      nxt_arm = 1'b0;
    end
    if (wr_status) begin
      nxt_trg = reg_wdata_in[`DBGTC_STS_TRG_MSB:`DBGTC_STS_TRG_LSB]; // R16
    end
  end

  // Flags: a match in a clearing cycle still sets the flag only on a re-arm write while already armed.
  always_comb begin
    nxt_flag_a = flag_a_ff;
    nxt_flag_b = flag_b_ff;
    nxt_flag_c = flag_c_ff;
    if (arm_restart || wr_status) begin
      nxt_flag_a = 1'b0; // R13
      nxt_flag_b = 1'b0; // R14
      nxt_flag_c = 1'b0; // R15
    end
    if (arm_ff && trig_a) begin
      nxt_flag_a = 1'b1; // R13
    end
    if (arm_ff && trig_b) begin
      nxt_flag_b = 1'b1; // R14
    end
    if (arm_ff && match_c_in) begin
      nxt_flag_c = 1'b1; // R15
    end
  end

  always_comb begin
    nxt_triggered = triggered_ff;
    if (arm_restart || !arm_ff) begin
      nxt_triggered = 1'b0;
    end else if (trig_event) begin
      nxt_triggered = 1'b1;
    end
  end

  // ********************
  // Capture qualification.
  // ********************
  wire logic store_window;
  wire logic normal_hit;
  wire logic dup_hit;
  wire logic detail_hit;
  wire logic mode_hit;
  wire logic event_mode;
  wire logic do_store;

  assign event_mode = (trg_ff == 4'h3) || (trg_ff == 4'h4);
  assign store_window = begin_ff ? (triggered_ff || trig_event) : !triggered_ff; // R7
  assign normal_hit = bus_valid_in && bus_cof_in;
  assign dup_hit = normal_hit && !(last_valid_ff && (bus_addr_in == last_store_ff)); // R10
  assign detail_hit = bus_valid_in && !bus_prog_fetch_in && !bus_free_in; // R11
  assign mode_hit = (cap_ff == DBGTC_CAP_NORMAL) ? normal_hit :
                    (cap_ff == DBGTC_CAP_DUP_SUPPRESS) ? dup_hit :
                    (cap_ff == DBGTC_CAP_DETAIL) ? detail_hit : 1'b0; // R9
  assign do_store = arm_ff && debug_enable_ff &&
                    (event_mode ? event_store : (store_window && mode_hit)); // R3

  // ********************
  // Read data.
  // ********************
  assign control_view = {debug_enable_ff, arm_ff, tsel_ff, begin_ff, brk_ff, 1'b0,
                         cap_ff}; // R20
  assign status_view = {flag_a_ff, flag_b_ff, flag_c_ff, 1'b0, trg_ff}; // R20
  assign read_mux = sel_control ? control_view :
                    sel_status ? status_view : `DBGTC_RST_RDATA;

  // ********************
  // Register updates.
  // ********************
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      debug_enable_ff <= 1'b0;
      arm_ff <= 1'b0;
      tsel_ff <= 1'b0;
      begin_ff <= 1'b0;
      brk_ff <= 1'b0;
      cap_ff <= DBGTC_CAP_NORMAL;
    end else begin
      debug_enable_ff <= nxt_debug_enable;
      arm_ff <= nxt_arm;
      tsel_ff <= nxt_tsel;
      begin_ff <= nxt_begin;
      brk_ff <= nxt_brk;
      cap_ff <= nxt_cap;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      trg_ff <= 4'h0;
      flag_a_ff <= 1'b0;
      flag_b_ff <= 1'b0;
      flag_c_ff <= 1'b0;
      triggered_ff <= 1'b0;
    end else begin
      trg_ff <= nxt_trg;
      flag_a_ff <= nxt_flag_a;
      flag_b_ff <= nxt_flag_b;
      flag_c_ff <= nxt_flag_c;
      triggered_ff <= nxt_triggered;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_ff <= `DBGTC_RST_RDATA;
    end else if (reg_rd_in) begin
      rdata_ff <= read_mux;
    end else begin
      rdata_ff <= `DBGTC_RST_RDATA;
    end
  end

  // ********************
  // Trace store path.
  // ********************
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      store_ff <= 1'b0;
      store_addr_ff <= '0;
    end else begin
      store_ff <= do_store; // R3
      store_addr_ff <= do_store ? bus_addr_in : store_addr_ff;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last_store_ff <= '0;
      last_valid_ff <= 1'b0;
    end else if (arm_restart) begin
      last_valid_ff <= 1'b0; // R10
    end else if (do_store) begin
      last_store_ff <= bus_addr_in; // R10
      last_valid_ff <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      profile_ff <= '0;
    end else if (instr_exec_in && (cap_ff == DBGTC_CAP_PROFILE)) begin
      profile_ff <= instr_addr_in; // R12
    end
  end

  // ********************
  // Break request and trigger outputs.
  // ********************
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      break_ff <= 1'b0;
      trigger_ff <= 1'b0;
    end else begin
      break_ff <= session_done_in && arm_ff && brk_ff && debug_enable_ff; // R8
      trigger_ff <= trig_event;
    end
  end

  assign reg_rdata_out = rdata_ff;
  assign debug_operation_enable_out = debug_enable_ff;
  assign armed_out = arm_ff;
  assign trigger_type_select_out = tsel_ff; // R5
  assign begin_trigger_out = begin_ff;
  assign capture_mode_field_out = cap_ff;
  assign trigger_mode_field_out = trg_ff;
  assign compare_enable_out = arm_ff; // R3
  assign trigger_out = trigger_ff;
  assign store_strobe_out = store_ff;
  assign store_addr_out = store_addr_ff;
  assign profile_addr_out = profile_ff;
  assign cpu_break_request_out = break_ff;
  assign break_tagged_out = tsel_ff; // R6

endmodule

// ==== dbgtc_sva.sv ====
`timescale 1ns/10ps

// ********************
// Port checker for the debug control block.
// ********************
module dbgtc_sva #(
  parameter int ADDR_W = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic secure_mode_in,
  input wire logic legacy_breakpoint_enable_in,
  input wire logic session_done_in,
  input wire logic bus_valid_in,
  input wire logic bus_prog_fetch_in,
  input wire logic bus_free_in,
  input wire logic debug_operation_enable_out,
  input wire logic armed_out,
  input wire logic trigger_type_select_out,
  input wire logic begin_trigger_out,
  input wire dbgtc_pkg::dbgtc_cap_t capture_mode_field_out,
  input wire logic [3:0] trigger_mode_field_out,
  input wire logic compare_enable_out,
  input wire logic store_strobe_out,
  input wire logic cpu_break_request_out,
  input wire logic break_tagged_out
);
  import dbgtc_pkg::*;
  logic ctl_wr;
  logic sts_wr;
  assign ctl_wr = reg_wr_in && reg_addr_in == 8'h20;
  assign sts_wr = reg_wr_in && reg_addr_in == 8'h21;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  legacy_lock_a: assert property (ctl_wr && legacy_breakpoint_enable_in |=> $stable(
    {debug_operation_enable_out, trigger_type_select_out, capture_mode_field_out}))
    else $error("control changed under legacy lock");
  secure_en_a: assert property ($rose(debug_operation_enable_out) |-> !$past(secure_mode_in))
    else $error("enable set in secure mode");
  arm_pair_a: assert property ($rose(armed_out) |-> debug_operation_enable_out &&
    $past(ctl_wr) && $past(reg_wdata_in[7])) else $error("arm set without enable");
  cmp_arm_a: assert property (compare_enable_out == armed_out)
    else $error("compare enable differs from arm");
  brk_type_a: assert property (break_tagged_out == trigger_type_select_out)
    else $error("break type differs from trigger select");
  armed_lock_a: assert property (armed_out && ctl_wr && !legacy_breakpoint_enable_in |=>
    $stable({trigger_type_select_out, begin_trigger_out, capture_mode_field_out}))
    else $error("control field changed while armed");
  sts_lock_a: assert property (armed_out && sts_wr |=> $stable(trigger_mode_field_out))
    else $error("trigger mode changed while armed");
  brk_req_a: assert property (cpu_break_request_out |-> $past(session_done_in) &&
    $past(armed_out) && $past(debug_operation_enable_out)) else $error("stray break");
  detail_store_a: assert property (store_strobe_out &&
    $past(capture_mode_field_out) == DBGTC_CAP_DETAIL &&
    !($past(trigger_mode_field_out) inside {4'h3, 4'h4}) |->
    $past(bus_valid_in) && !$past(bus_prog_fetch_in) && !$past(bus_free_in))
    else $error("detail store of excluded cycle");
  trg_wr_a: assert property (!armed_out && sts_wr |=>
    trigger_mode_field_out == $past(reg_wdata_in[3:0])) else $error("trigger mode not written");
  rsvd_zero_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) == 8'h20 |->
    !reg_rdata_out[2]) else $error("reserved control bit read as one");
  cover property ($rose(armed_out));
  cover property (cpu_break_request_out);
  cover property (store_strobe_out && capture_mode_field_out == DBGTC_CAP_DETAIL);
endmodule

// ==== dbgtc_cpu_model.sv ====
`timescale 1ns/10ps

// ********************
// CPU and bus model: random bus cycles and instructions, counts break requests.
// ********************
module dbgtc_cpu_model (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic cpu_break_request_in,
  output logic bus_valid_out,
  output logic bus_prog_fetch_out,
  output logic bus_free_out,
  output logic bus_cof_out,
  output logic [15:0] bus_addr_out,
  output logic instr_exec_out,
  output logic [15:0] instr_addr_out,
  output logic [15:0] last_instr_out,
  output int n_break_out
);
  logic [31:0] r;
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {bus_valid_out, bus_prog_fetch_out, bus_free_out, bus_cof_out} <= 4'h0;
      instr_exec_out <= 1'b0;
      bus_addr_out <= 16'h0000;
      instr_addr_out <= 16'h0000;
      last_instr_out <= 16'h0000;
      n_break_out <= 0;
    end else begin
      r = $urandom;
      bus_valid_out <= r[0];
      bus_prog_fetch_out <= r[1];
      bus_free_out <= r[2] & ~r[1];
      bus_cof_out <= r[1] & r[3];
      bus_addr_out <= r[31:16];
      instr_exec_out <= r[4];
      instr_addr_out <= r[15:0];
      if (instr_exec_out) last_instr_out <= instr_addr_out;
      if (cpu_break_request_in) n_break_out <= n_break_out + 1;
    end
  end
endmodule

// ==== test_debug_trace_control.sv ====
`timescale 1ns/10ps

// ********************
// Self-checking bench of the debug control block.
// ********************
module test_debug_trace_control;
  import dbgtc_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic secure_mode_in = 1'b0;
  logic legacy_breakpoint_enable_in = 1'b0;
  logic match_a_in = 1'b0;
  logic match_b_in = 1'b0;
  logic match_c_in = 1'b0;
  logic session_done_in = 1'b0;
  logic bus_valid_in, bus_prog_fetch_in, bus_free_in, bus_cof_in, instr_exec_in;
  logic [15:0] bus_addr_in, instr_addr_in, last_instr, store_addr_out, profile_addr_out;
  logic [7:0] reg_rdata_out;
  logic debug_operation_enable_out, armed_out, trigger_type_select_out, begin_trigger_out;
  logic compare_enable_out, trigger_out, store_strobe_out, cpu_break_request_out;
  logic break_tagged_out;
  dbgtc_cap_t capture_mode_field_out;
  logic [3:0] trigger_mode_field_out;
  logic [7:0] ctl_m, d, w, s;
  logic [7:0] hand [5] = '{8'h80, 8'h40, 8'hc7, 8'hfc, 8'h00};
  logic [3:0] modes [3] = '{4'hc, 4'h1, 4'h7};
  int n_break;
  int n_fail = 0;
  int compares = 0;

  dbgtc_ctrl DUT (.ref_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .secure_mode_in, .legacy_breakpoint_enable_in, .match_a_in, .match_b_in,
    .match_c_in, .in_range_in(match_b_in), .bus_valid_in, .bus_prog_fetch_in, .bus_free_in,
    .bus_cof_in, .bus_addr_in, .instr_exec_in, .instr_addr_in, .session_done_in,
    .debug_operation_enable_out, .armed_out, .trigger_type_select_out, .begin_trigger_out,
    .capture_mode_field_out, .trigger_mode_field_out, .compare_enable_out, .trigger_out,
    .store_strobe_out, .store_addr_out, .profile_addr_out, .cpu_break_request_out,
    .break_tagged_out);
  dbgtc_cpu_model cpu (.ref_clk_in, .rst_n_in, .cpu_break_request_in(cpu_break_request_out),
    .bus_valid_out(bus_valid_in), .bus_prog_fetch_out(bus_prog_fetch_in),
    .bus_free_out(bus_free_in), .bus_cof_out(bus_cof_in), .bus_addr_out(bus_addr_in),
    .instr_exec_out(instr_exec_in), .instr_addr_out(instr_addr_in),
    .last_instr_out(last_instr), .n_break_out(n_break));

  always #5 ref_clk_in = ~ref_clk_in;

  function automatic logic [7:0] ctl_next(input logic [7:0] o, input logic [7:0] w,
      input logic sec, input logic leg);
    logic [7:0] n;
    n = w & 8'hfb;
    if (o[6]) n = {w[7:6], o[5:0]};
    if (sec) n[7:6] = 2'b00;
    if (!n[7]) n[6] = 1'b0;
    return leg ? o : n;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    v = reg_rdata_out;
  endtask

  task automatic ctl(input logic [7:0] v);
    ctl_m = ctl_next(ctl_m, v, secure_mode_in, legacy_breakpoint_enable_in);
    wr(8'h20, v);
    rd(8'h20, d);
    chk(d, ctl_m);
    chk({debug_operation_enable_out, armed_out, trigger_type_select_out, begin_trigger_out,
      2'b00, capture_mode_field_out}, ctl_m & 8'hf3);
  endtask

  task automatic pulse(input logic [3:0] m);
    @(posedge ref_clk_in);
    {session_done_in, match_a_in, match_b_in, match_c_in} <= m;
    @(posedge ref_clk_in);
    {session_done_in, match_a_in, match_b_in, match_c_in} <= 4'h0;
    #1;
  endtask

  task automatic give_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_fail++;
    give_verdict();
  end

  initial begin
    void'($urandom(2807));
    ctl_m = 8'h00;
    repeat (16) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    rd(8'h20, d);
    chk(d, 8'h00);
    rd(8'h21, d);
    chk(d, 8'h00);
    $display("test reset done");
    foreach (hand[i]) ctl(hand[i]);
    for (int i = 0; i < 24; i++) begin
      {w, s} = 16'($urandom);
      legacy_breakpoint_enable_in <= s[0] & s[1];
      secure_mode_in <= s[2] & (ctl_m[7:6] == 2'b00);
      @(posedge ref_clk_in);
      ctl(w);
    end
    legacy_breakpoint_enable_in <= 1'b0;
    secure_mode_in <= 1'b0;
    @(posedge ref_clk_in);
    ctl(8'h00);
    $display("test control done");
    for (int t = 0; t < 16; t++) begin
      wr(8'h21, {4'h1, t[3:0]});
      rd(8'h21, d);
      chk(d, {4'h0, t[3:0]});
      chk(trigger_mode_field_out, t[3:0]);
    end
    $display("test status done");
    foreach (modes[k]) begin
      wr(8'h21, {4'h0, modes[k]});
      ctl(8'hc0);
      pulse(4'b0010);
      chk(trigger_out, modes[k] != 4'hc);
      rd(8'h21, d);
      chk(d, {modes[k] == 4'h7, modes[k] != 4'hc, 2'b00, modes[k]});
      pulse(4'b0100);
      rd(8'h21, d);
      chk(d[7], 1'b1);
      pulse(4'b0001);
      wr(8'h21, 8'h00);
      rd(8'h21, d);
      chk({d[5], d[3:0]}, {1'b1, modes[k]});
      ctl(8'h80);
      wr(8'h21, {4'h0, modes[k]});
      rd(8'h21, d);
      chk(d[7:5], 3'b000);
    end
    ctl(8'hc0);
    pulse(4'b0110);
    ctl(8'h80);
    ctl(8'hc0);
    rd(8'h21, d);
    chk(d[7], 1'b0);
    $display("test flags done");
    for (int b = 0; b < 2; b++) begin
      ctl({4'hc, b[0], 3'b000});
      pulse(4'b1000);
      chk(cpu_break_request_out, b[0]);
      ctl_m[6] = 1'b0;
      chk(armed_out, 1'b0);
    end
    #10;
    chk(n_break, 1);
    $display("test break done");
    ctl(8'hc3);
    repeat (40) @(posedge ref_clk_in);
    #1;
    chk(profile_addr_out, last_instr);
    ctl(8'h80);
    $display("test profile done");
    give_verdict();
  end
endmodule

bind dbgtc_ctrl dbgtc_sva #(.ADDR_W(ADDR_W)) u_sva (.ref_clk_in, .rst_n_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .secure_mode_in,
  .legacy_breakpoint_enable_in, .session_done_in, .bus_valid_in, .bus_prog_fetch_in,
  .bus_free_in, .debug_operation_enable_out, .armed_out, .trigger_type_select_out,
  .begin_trigger_out, .capture_mode_field_out, .trigger_mode_field_out, .compare_enable_out,
  .store_strobe_out, .cpu_break_request_out, .break_tagged_out);
